// *** pll_multiplier_and_rc_trim.sv ***
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
// clock generator configuration: loop feedback divisor and rc oscillator trim
module pll_multiplier_and_rc_trim #(
    parameter int unsigned ADDR_W = pll_trim_pkg::ADDR_W,
    parameter int unsigned DATA_W = pll_trim_pkg::DATA_W
) (
    input  wire logic                                      clk,
    input  wire logic                                      arst_n,
    input  wire logic [ADDR_W-1:0]                         regAddr,
    input  wire logic [DATA_W-1:0]                         regWrData,
    input  wire logic                                      regWr,
    input  wire logic                                      regRd,
    output logic      [DATA_W-1:0]                         regRdData,
    output logic      [pll_trim_pkg::MULT_CODE_W-1:0]      multiplierCode,
    output logic      [pll_trim_pkg::MULT_VAL_W-1:0]       multiplierValue,
    output logic      [pll_trim_pkg::TRIM_W-1:0]           trimCode,
    output logic signed [pll_trim_pkg::PCT_W-1:0]          trimMilliPct,
    output logic      [pll_trim_pkg::FREQ_W-1:0]           oscTargetHz,
    output logic                                           cfgUpdate
);

    localparam int unsigned MCW = pll_trim_pkg::MULT_CODE_W;
    localparam int unsigned MVW = pll_trim_pkg::MULT_VAL_W;
    localparam int unsigned TW  = pll_trim_pkg::TRIM_W;
    localparam int unsigned PW  = pll_trim_pkg::PCT_W;
    localparam int unsigned FW  = pll_trim_pkg::FREQ_W;

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rstSync_ff;
    logic       rstN;

    // assertion is immediate, release waits two edges to avoid metastability
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_ff <= 2'h0;
        end else begin
            rstSync_ff <= {rstSync_ff[0], 1'b1};
        end
    end

    assign rstN = rstSync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    // zero extends a field into a bus word, upper bits always zero
    function automatic logic [DATA_W-1:0] padWord(input logic [DATA_W-1:0] field,
                                                  input int unsigned       width);
        logic [DATA_W-1:0] mask;
        mask    = DATA_W'((32'h1 << width) - 32'h1);
        padWord = field & mask;
    endfunction : padWord

    // multiplier seen by the loop for a given feedback code
    function automatic logic [MVW-1:0] multOf(input logic [MCW-1:0] code);
        multOf = MVW'(code) + pll_trim_pkg::MULT_OFFSET;
    endfunction : multOf

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    logic hitFeedback;
    logic hitTrim;
    logic hitMultStat;
    logic hitFreqStat;

    always_comb begin
        hitFeedback = (regAddr == pll_trim_pkg::OFS_FEEDBACK_DIV);
        hitTrim     = (regAddr == pll_trim_pkg::OFS_OSC_TRIM);
        hitMultStat = (regAddr == pll_trim_pkg::OFS_MULT_STATUS);
        hitFreqStat = (regAddr == pll_trim_pkg::OFS_FREQ_STATUS);
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [MCW-1:0] multCode_ff;
    logic [MCW-1:0] nxt_multCode;
    logic [TW-1:0]  trim_ff;
    logic [TW-1:0]  nxt_trim;
    logic           update_ff;
    logic           nxt_update;

    // only the implemented low bits are stored; upper write bits drop away
    always_comb begin
        nxt_multCode = multCode_ff;
        nxt_trim     = trim_ff;
        nxt_update   = 1'b0;
        if (regWr && hitFeedback) begin
            nxt_multCode = regWrData[pll_trim_pkg::MULT_CODE_LSB +: MCW];
            // a rewrite of the same value still tells the loop to relock
            nxt_update   = 1'b1;
        end
        if (regWr && hitTrim) begin
            nxt_trim   = regWrData[pll_trim_pkg::TRIM_LSB +: TW];
            nxt_update = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            multCode_ff <= pll_trim_pkg::FEEDBACK_DIV_RST[MCW-1:0];
            trim_ff     <= pll_trim_pkg::OSC_TRIM_RST[TW-1:0];
            update_ff   <= 1'b0;
        end else begin
            multCode_ff <= nxt_multCode;
            trim_ff     <= nxt_trim;
            update_ff   <= nxt_update;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // derived outputs for the loop and the oscillator
    logic [MVW-1:0]       multVal_ff;
    logic [MVW-1:0]       nxt_multVal;
    logic signed [PW-1:0] pct_ff;
    logic signed [PW-1:0] nxt_pct;

    // computed from the next values so they move in step with the codes
    always_comb begin
        nxt_multVal = multOf(nxt_multCode);
        // signed code times 375 thousandths: +0.375 % per step, -12 % at the bottom
        nxt_pct     = PW'($signed(nxt_trim) * $signed(PW'(pll_trim_pkg::STEP_MILLI_PCT)));
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            multVal_ff <= pll_trim_pkg::MULT_VAL_RST;
            pct_ff     <= '0;
        end else begin
            multVal_ff <= nxt_multVal;
            pct_ff     <= nxt_pct;
        end
    end

    // expected frequency lags the trim register by one cycle
    logic [FW-1:0] freqHz;

    osc_freq_calc #(
        .TRIM_W (TW),
        .FREQ_W (FW)
    ) u_freq (
        .clk      (clk),
        .rstN     (rstN),
        .trimCode ($signed(trim_ff)),
        .freqHz   (freqHz)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read path: data one cycle after the strobe, zero otherwise
    logic [DATA_W-1:0] rdData_ff;
    logic [DATA_W-1:0] nxt_rdData;

    // unmapped addresses read as zero so software never sees stale data
    always_comb begin
        nxt_rdData = '0;
        if (regRd) begin
            case (1'b1)
                hitFeedback: nxt_rdData = padWord(DATA_W'(multCode_ff), MCW);
                hitTrim:     nxt_rdData = padWord(DATA_W'(trim_ff), TW);
                hitMultStat: nxt_rdData = padWord(DATA_W'(multVal_ff), MVW);
                // frequency in kilohertz fits the word; hertz would not
                hitFreqStat: nxt_rdData = DATA_W'(freqHz / FW'(1000));
                default:     nxt_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdData_ff <= '0;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    assign regRdData       = rdData_ff;
    assign multiplierCode  = multCode_ff;
    assign multiplierValue = multVal_ff;
    assign trimCode        = trim_ff;
    assign trimMilliPct    = pct_ff;
    assign oscTargetHz     = freqHz;
    assign cfgUpdate       = update_ff;

endmodule : pll_multiplier_and_rc_trim

// *** pll_trim_pkg.sv ***
// Operation
// - feedback divisor: 9-bit code, multiplier code+2, reset code 48 (multiplier 50)
// - trim code zero gives 7.37 MHz, reset value
// - each positive trim step adds 0.375 percent
// - negative steps subtract 0.375 percent, to -12 percent
package pll_trim_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register bus geometry
    localparam int unsigned ADDR_W  = 4;
    localparam int unsigned DATA_W  = 16;

    // byte offsets of the four registers
    localparam logic [ADDR_W-1:0] OFS_FEEDBACK_DIV = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_OSC_TRIM     = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MULT_STATUS  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_FREQ_STATUS  = 4'hC;

    ////////////////////////////////////////////////////////////////////////////
    // field layout
    localparam int unsigned MULT_CODE_W  = 9;
    localparam int unsigned MULT_CODE_LSB = 0;
    localparam int unsigned MULT_VAL_W   = 10;
    localparam int unsigned TRIM_W       = 6;
    localparam int unsigned TRIM_LSB     = 0;

    // the multiplier is the code plus this offset
    localparam logic [MULT_VAL_W-1:0] MULT_OFFSET = 10'h002;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [DATA_W-1:0]      FEEDBACK_DIV_RST = 16'h0030;
    localparam logic [DATA_W-1:0]      OSC_TRIM_RST     = 16'h0000;
    localparam logic [MULT_VAL_W-1:0]  MULT_VAL_RST     = 10'h032;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator figures
    localparam int unsigned FREQ_W          = 23;
    localparam int unsigned NOMINAL_HZ      = 7370000;
    // one trim step is 27637.5 Hz; kept in half hertz to stay exact
    localparam int unsigned STEP_HALF_HZ    = 55275;
    localparam int unsigned PCT_W           = 15;
    // one trim step in thousandths of a percent
    localparam int unsigned STEP_MILLI_PCT  = 375;

    localparam logic [FREQ_W-1:0] NOMINAL_FREQ = 23'h707510;

endpackage : pll_trim_pkg

// *** osc_freq_calc.sv ***
`timescale 1ns/10ps
// turns a signed trim code into the expected oscillator frequency
module osc_freq_calc #(
    parameter int unsigned TRIM_W = pll_trim_pkg::TRIM_W,
    parameter int unsigned FREQ_W = pll_trim_pkg::FREQ_W
) (
    input  wire logic                     clk,
    input  wire logic                     rstN,
    input  wire logic signed [TRIM_W-1:0] trimCode,
    output logic             [FREQ_W-1:0] freqHz
);

    logic signed [31:0] offsetHalfHz;
    logic signed [31:0] totalHalfHz;
    logic        [FREQ_W-1:0] nxt_freqHz;
    logic        [FREQ_W-1:0] freqHz_ff;

    ////////////////////////////////////////////////////////////////////////////
    // linear model: nominal plus code times 0.375 percent, rounded to a hertz
    always_comb begin
        offsetHalfHz = 32'(trimCode) * $signed(32'(pll_trim_pkg::STEP_HALF_HZ));
        totalHalfHz  = $signed(32'(2 * pll_trim_pkg::NOMINAL_HZ)) + offsetHalfHz;
        // adding one before halving rounds the half hertz up
        nxt_freqHz   = FREQ_W'((totalHalfHz + 32'sd1) >>> 1);
    end

    // registered so the result is a clean flip-flop output
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            freqHz_ff <= pll_trim_pkg::NOMINAL_FREQ;
        end else begin
            freqHz_ff <= nxt_freqHz;
        end
    end

    assign freqHz = freqHz_ff;

endmodule : osc_freq_calc

// *** pll_multiplier_and_rc_trim_sva.sv ***
`timescale 1ns/10ps
module pll_multiplier_and_rc_trim_sva (
    input wire logic               clk,
    input wire logic               arst_n,
    input wire logic [3:0]         regAddr,
    input wire logic [15:0]        regWrData,
    input wire logic               regWr,
    input wire logic               regRd,
    input wire logic [15:0]        regRdData,
    input wire logic [8:0]         multiplierCode,
    input wire logic [9:0]         multiplierValue,
    input wire logic [5:0]         trimCode,
    input wire logic signed [14:0] trimMilliPct,
    input wire logic               cfgUpdate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    // writes land one edge later, bits above the field dropped
    chk_mult_write: assert property (
        regWr && regAddr == 4'h0 |=> multiplierCode == $past(regWrData[8:0]))
        else $error("feedback code not taken from write");
    chk_trim_write: assert property (
        regWr && regAddr == 4'h4 |=> trimCode == $past(regWrData[5:0]))
        else $error("trim code not taken from write");
    chk_trim_hold: assert property (
        !(regWr && regAddr == 4'h4) |=> $stable(trimCode))
        else $error("trim code moved without a write");
    chk_mult_value: assert property (
        multiplierValue == {1'b0, multiplierCode} + 10'h002)
        else $error("multiplier is not code plus two");
    chk_trim_pct: assert property (
        int'(trimMilliPct) == int'($signed(trimCode)) * 375)
        else $error("trim percent wrong");
    // read data stands only in the cycle after the strobe
    chk_rd_idle: assert property (!regRd |=> regRdData == 16'h0000)
        else $error("read data outside read slot");
    chk_rd_trim: assert property (
        regRd && regAddr == 4'h4 |=> regRdData == {10'h000, $past(trimCode)})
        else $error("trim readback wrong");
    chk_rd_mult: assert property (
        regRd && regAddr == 4'h0 |=> regRdData == {7'h00, $past(multiplierCode)})
        else $error("feedback readback wrong");
    chk_cfg_cause: assert property (
        cfgUpdate |-> $past(regWr) && ($past(regAddr) inside {4'h0, 4'h4}))
        else $error("update pulse without write");
    cov_trim_wr: cover property (regWr && regAddr == 4'h4 ##1 cfgUpdate);
    cov_mult_rd: cover property (regRd && regAddr == 4'h0);
    cov_neg_trim: cover property (trimCode == 6'h20);
endmodule : pll_multiplier_and_rc_trim_sva
bind pll_multiplier_and_rc_trim pll_multiplier_and_rc_trim_sva chk_u (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .multiplierCode(multiplierCode), .multiplierValue(multiplierValue),
    .trimCode(trimCode), .trimMilliPct(trimMilliPct), .cfgUpdate(cfgUpdate));

// *** test_pll_multiplier_and_rc_trim.sv ***
`timescale 1ns/10ps
module test_pll_multiplier_and_rc_trim;
    logic               clk = 1'b0;
    logic               arst_n = 1'b0;
    logic [3:0]         regAddr = 4'h0;
    logic [15:0]        regWrData = 16'h0000;
    logic               regWr = 1'b0;
    logic               regRd = 1'b0;
    logic [15:0]        regRdData;
    logic [8:0]         multiplierCode;
    logic [9:0]         multiplierValue;
    logic [5:0]         trimCode;
    logic signed [14:0] trimMilliPct;
    logic [22:0]        oscTargetHz;
    logic               cfgUpdate;
    logic [15:0]        d;
    int num_errors = 0, checks_done = 0, mult = 48, trim = 0, t, hz;
    int codes[6] = '{1, 2, 6'h3F, 6'h20, 6'h1E, 0};
    always #25 clk = ~clk;
    pll_multiplier_and_rc_trim dut_u (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .multiplierCode(multiplierCode), .multiplierValue(multiplierValue),
        .trimCode(trimCode), .trimMilliPct(trimMilliPct), .oscTargetHz(oscTargetHz),
        .cfgUpdate(cfgUpdate));
    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic cmp(input string n, input logic signed [31:0] e, g);
        checks_done++;
        if (e !== g) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", n, e, g);
        end
    endtask : cmp
    // bus cycles; the model follows each write, keeping only the field bits
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk);
        regWr <= 1'b0;
        #1 cmp("cfgUpdate", (a == 4'h0 || a == 4'h4), cfgUpdate);
        if (a == 4'h0) mult = v[8:0];
        if (a == 4'h4) trim = v[5:0];
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask : rd
    // odd trims land on a half hertz; the half is rounded up
    task automatic verify();
        t = trim >= 32 ? trim - 64 : trim;
        hz = (14740000 + t * 55275 + 1) / 2;
        rd(4'h0);
        cmp("fbd_read", mult, d);
        rd(4'h4);
        cmp("trim_read", trim, d);
        rd(4'h8);
        cmp("mult_read", mult + 2, d);
        cmp("multiplierCode", mult, multiplierCode);
        cmp("multiplierValue", mult + 2, multiplierValue);
        cmp("trimMilliPct", t * 375, trimMilliPct);
        cmp("oscTargetHz", hz, oscTargetHz);
        rd(4'hC);
        cmp("freq_khz_read", hz / 1000, d);
    endtask : verify
    ////////////////////////////////////////
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
    initial begin
        t = $urandom(9993);
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        verify();
        $display("reset values done");
        foreach (codes[i]) begin
            wr(4'h4, 16'hFFC0 | codes[i]);
            verify();
        end
        $display("trim codes done");
        wr(4'h0, 16'hFE00);
        verify();
        wr(4'h0, 16'hFFFF);
        verify();
        repeat (10) begin
            wr(4'h0, 16'($urandom));
            wr(4'h4, 16'($urandom));
            verify();
        end
        $display("multiplier codes done");
        wr(4'h8, 16'h0000);
        wr(4'hC, 16'h0000);
        wr(4'h2, 16'hFFFF);
        rd(4'h2);
        cmp("unmapped_read", 0, d);
        verify();
        $display("unmapped done");
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        mult = 48;
        trim = 0;
        cmp("rst_mult", 48, multiplierCode);
        cmp("rst_trim", 0, trimCode);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        verify();
        $display("second reset done");
        give_verdict();
    end
endmodule : test_pll_multiplier_and_rc_trim
